// >>> rtl/fcs_defines.vh
// register map, field positions, reset values and timing counts of the clock source control
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// register byte offsets
`define FCS_OFF_CTRL1          8'h00
`define FCS_OFF_CTRL2          8'h04
`define FCS_OFF_TRIM           8'h08
`define FCS_OFF_STATUS         8'h0C

// control 1 fields
`define FCS_C1_CLKSEL_LO       0
`define FCS_C1_CLKSEL_HI       1
`define FCS_C1_REFERENCE_DIVIDER_LO         2
`define FCS_C1_REFERENCE_DIVIDER_HI         4
`define FCS_C1_REFSEL          5
`define FCS_C1_IRC_OE          6
`define FCS_C1_IRC_STOPEN      7

// control 2 fields
`define FCS_C2_BUS_DIVIDER_LO         0
`define FCS_C2_BUS_DIVIDER_HI         1
`define FCS_C2_FLL_PD          2
`define FCS_C2_ERC_OE          3
`define FCS_C2_ERC_STOPEN      4

// trim fields
`define FCS_TR_COARSE_LO       0
`define FCS_TR_COARSE_HI       7
`define FCS_TR_FINE            8

// status fields
`define FCS_ST_REFST           0
`define FCS_ST_CLKST_LO        1
`define FCS_ST_CLKST_HI        2
`define FCS_ST_FLL_ON          3
`define FCS_ST_FFE             4

// clock select encodings
`define FCS_CS_FLL             2'b00
`define FCS_CS_IRC             2'b01
`define FCS_CS_ERC             2'b10
`define FCS_CS_RSVD            2'b11

// reset values
`define FCS_RST_CLKSEL         2'b00
`define FCS_RST_REFERENCE_DIVIDER           3'b000
`define FCS_RST_REFSEL         1'b1
`define FCS_RST_BUS_DIVIDER           2'b01
`define FCS_RST_FLL_PD         1'b0

// axi responses
`define FCS_RESP_OKAY          2'b00
`define FCS_RESP_SLVERR        2'b10

// timing counts
`define FCS_SWITCH_CYCLES      3
`define FCS_FLL_MULT           11'h400
`define FCS_BUS_DIVIDER_QUAL_BASE     2

`endif

// >>> rtl/fcs_edge_sync.v
// two-stage synchroniser with rising edge detect for a sampled clock pin
`default_nettype none

module fcs_edge_sync (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // pin side
  input  wire pin_in,
  // synchronised side
  output wire level_out,
  output wire rise_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_out = s2_reg;
  assign rise_out  = s2_reg & ~s3_reg;

endmodule // fcs_edge_sync

`default_nettype wire

// >>> rtl/fcs_clock_source.v
// clock source mode control: reference and output selection, dividers, trim, aux clocks
//
// How it works
// [R01] software writes reference or clock select and the divider in one write
// [R02] reference change commits after few divided-reference cycles; then status updates
// [R03] clock select commits after few new-clock cycles; absent clock keeps old one
// [R04] bus divider write changes the bus clock ratio at once
// [R05] fll power down in bypass disables fll; software clears it before engaging
// [R06] internal reference output enable shows internal reference on aux output
// [R07] trim drives oscillator period: larger slows, smaller speeds up
// [R08] coarse and fine trim keep their value through reset
// [R09] internal reference runs in stop when stop enable and output enable set
// [R10] boot software may load factory trim without the fine bit
// [R11] external reference output enable shows external reference on aux output
// [R12] internal reference selected means fll never uses external reference
// [R13] external reference runs in stop when stop enable and output enable set
// [R14] divided fll reference is output as fixed frequency clock
// [R15] qualifier high when bus clock is at least four times fixed clock; always in engaged
// [R16] bypass qualifier follows bus divider and reference divider table
// [R17] bus divider codes divide by 1, 2, 4 and 8
// [R18] fll locks to 1024 times divided reference
// [R19] clock select 00 fll, 01 internal, 10 external reference
// [R20] bypass disables fll only with power down set and debug inactive
// [R21] output mux switches without glitches or truncated pulses
// [R22] reference and clock status pass two-stage synchronisers to the bus side
`default_nettype none
`include "fcs_defines.vh"

module fcs_clock_source #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 7
) (
  // clock and reset
  input  wire               aclk,
  input  wire               aresetn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]         s_axi_awprot,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // axi4-lite write response
  output wire [1:0]         s_axi_bresp,
  output wire               s_axi_bvalid,
  input  wire               s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]         s_axi_arprot,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // axi4-lite read data
  output wire [31:0]        s_axi_rdata,
  output wire [1:0]         s_axi_rresp,
  output wire               s_axi_rvalid,
  input  wire               s_axi_rready,
  // clock sources, sampled pins
  input  wire               internal_ref_clk_in,
  input  wire               external_ref_clk_in,
  input  wire               fll_clk_in,
  // system state, same clock domain
  input  wire               stop_mode,
  input  wire               background_debug_mode,
  // generated clocks
  output wire               main_clock_out,
  output wire               bus_clock_out,
  output wire               internal_ref_clock_out,
  output wire               external_ref_clock_out,
  output wire               fixed_frequency_clock,
  output wire               fixed_frequency_qualifier,
  // fll and oscillator control
  output wire               fll_enable,
  output wire               fll_reference_out,
  output wire               fll_relock,
  output wire [10:0]        fll_multiplier,
  output wire               internal_ref_osc_enable,
  output wire               external_ref_osc_enable,
  output wire [7:0]         trim_out,
  output wire               fine_adjust_out
);

  // decode of a byte address into a register index, 3'd4 when unmapped
  function [2:0] fcs_decode;
    input [ADDR_W-1:0] addr;
    begin
      case ({addr[ADDR_W-1:2], 2'b00})
        `FCS_OFF_CTRL1:  fcs_decode = 3'd0;
        `FCS_OFF_CTRL2:  fcs_decode = 3'd1;
        `FCS_OFF_TRIM:   fcs_decode = 3'd2;
        `FCS_OFF_STATUS: fcs_decode = 3'd3;
        default:         fcs_decode = 3'd4;
      endcase
    end
  endfunction

  // tap of a binary divider chain: code 0 passes the level, code n picks bit n-1
  function fcs_tap;
    input             lvl;
    input [CNT_W-1:0] cnt;
    input [2:0]       code;
    begin
      if (code == 3'd0) begin
        fcs_tap = lvl;
      end else begin
        fcs_tap = cnt[code - 3'd1];
      end
    end
  endfunction

  // clock chosen by a select code, reserved code gives a quiet low
  function fcs_pick;
    input [1:0] sel;
    input       f;
    input       i;
    input       e;
    begin
      case (sel)
        `FCS_CS_FLL: fcs_pick = f;
        `FCS_CS_IRC: fcs_pick = i;
        `FCS_CS_ERC: fcs_pick = e;
        default:     fcs_pick = 1'b0;
      endcase
    end
  endfunction

  // synchronised clock pins
  wire irc_lvl;
  wire irc_rise;
  wire erc_lvl;
  wire erc_rise;
  wire fll_lvl;
  wire fll_rise;

  fcs_edge_sync u_irc_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (internal_ref_clk_in),
    .level_out (irc_lvl),
    .rise_out  (irc_rise)
  );

  fcs_edge_sync u_erc_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (external_ref_clk_in),
    .level_out (erc_lvl),
    .rise_out  (erc_rise)
  );

  fcs_edge_sync u_fll_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (fll_clk_in),
    .level_out (fll_lvl),
    .rise_out  (fll_rise)
  );

  // software registers
  reg [1:0]        clock_select_reg;
  reg [2:0]        reference_divider_reg;
  reg              reference_select_reg;
  reg              internal_ref_output_enable_reg;
  reg              internal_ref_stop_enable_reg;
  reg [1:0]        bus_divider_reg;
  reg              fll_power_down_reg;
  reg              external_ref_output_enable_reg;
  reg              external_ref_stop_enable_reg;
  reg [7:0]        trim_register_reg;
  reg              fine_adjust_bit_reg;

  // axi state
  reg              awready_reg;
  reg              wready_reg;
  reg              aw_held_reg;
  reg              w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0]       w_data_reg;
  reg [3:0]        w_strb_reg;
  reg              bvalid_reg;
  reg [1:0]        bresp_reg;
  reg              arready_reg;
  reg              rvalid_reg;
  reg [31:0]       rdata_reg;
  reg [1:0]        rresp_reg;

  // clock path state
  reg [CNT_W-1:0]  irc_cnt_reg;
  reg [CNT_W-1:0]  erc_cnt_reg;
  reg              irc_div_prev_reg;
  reg              erc_div_prev_reg;
  reg              reference_status_reg;
  reg [1:0]        ref_sw_cnt_reg;
  reg              fll_relock_reg;
  reg [1:0]        clock_status_reg;
  reg [1:0]        clk_sw_cnt_reg;
  reg              main_clock_reg;
  reg              main_prev_reg;
  reg [2:0]        bus_cnt_reg;
  reg              bus_clock_reg;
  reg              irc_out_reg;
  reg              erc_out_reg;
  reg              ffclk_reg;
  reg              ffe_reg;
  reg              fll_enable_reg;
  reg              irc_osc_en_reg;
  reg              erc_osc_en_reg;
  reg              refst_s1_reg;
  reg              refst_s2_reg;
  reg [1:0]        clkst_s1_reg;
  reg [1:0]        clkst_s2_reg;

  wire [2:0] wr_idx = fcs_decode(aw_addr_reg);
  wire [2:0] rd_idx = fcs_decode(s_axi_araddr);
  wire       wr_go  = aw_held_reg & w_held_reg & ~bvalid_reg;

  // axi write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_idx == 3'd4) ? `FCS_RESP_SLVERR : `FCS_RESP_OKAY;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // control registers; select fields and divider share one word so one write moves all
  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_select_reg               <= `FCS_RST_CLKSEL;
      reference_divider_reg          <= `FCS_RST_REFERENCE_DIVIDER;
      reference_select_reg           <= `FCS_RST_REFSEL;
      internal_ref_output_enable_reg <= 1'b0;
      internal_ref_stop_enable_reg   <= 1'b0;
      bus_divider_reg                <= `FCS_RST_BUS_DIVIDER;
      fll_power_down_reg             <= `FCS_RST_FLL_PD;
      external_ref_output_enable_reg <= 1'b0;
      external_ref_stop_enable_reg   <= 1'b0;
    end else if (wr_go && w_strb_reg[0]) begin
      if (wr_idx == 3'd0) begin
        clock_select_reg      <= w_data_reg[`FCS_C1_CLKSEL_HI:`FCS_C1_CLKSEL_LO]; // [R01]
        reference_divider_reg <= w_data_reg[`FCS_C1_REFERENCE_DIVIDER_HI:`FCS_C1_REFERENCE_DIVIDER_LO]; // [R01]
        reference_select_reg  <= w_data_reg[`FCS_C1_REFSEL];
        internal_ref_output_enable_reg <= w_data_reg[`FCS_C1_IRC_OE];
        internal_ref_stop_enable_reg   <= w_data_reg[`FCS_C1_IRC_STOPEN];
      end
      if (wr_idx == 3'd1) begin
        bus_divider_reg                <= w_data_reg[`FCS_C2_BUS_DIVIDER_HI:`FCS_C2_BUS_DIVIDER_LO];
        fll_power_down_reg             <= w_data_reg[`FCS_C2_FLL_PD];
        external_ref_output_enable_reg <= w_data_reg[`FCS_C2_ERC_OE];
        external_ref_stop_enable_reg   <= w_data_reg[`FCS_C2_ERC_STOPEN];
      end
    end
  end

  // trim has no reset so a value loaded at boot survives later resets
  always @(posedge aclk) begin
    if (wr_go && wr_idx == 3'd2) begin
      if (w_strb_reg[0]) begin
        trim_register_reg <= w_data_reg[`FCS_TR_COARSE_HI:`FCS_TR_COARSE_LO]; // [R08] [R10]
      end
      if (w_strb_reg[1]) begin
        fine_adjust_bit_reg <= w_data_reg[`FCS_TR_FINE]; // [R08]
      end
    end
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `FCS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `FCS_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      case (rd_idx)
        3'd0: rdata_reg[7:0] <= {internal_ref_stop_enable_reg, internal_ref_output_enable_reg,
                                 reference_select_reg, reference_divider_reg,
                                 clock_select_reg};
        3'd1: rdata_reg[4:0] <= {external_ref_stop_enable_reg, external_ref_output_enable_reg,
                                 fll_power_down_reg, bus_divider_reg};
        3'd2: rdata_reg[8:0] <= {fine_adjust_bit_reg, trim_register_reg};
        3'd3: rdata_reg[4:0] <= {ffe_reg, fll_enable_reg, clkst_s2_reg, refst_s2_reg}; // [R22]
        default: rresp_reg <= `FCS_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // reference dividers, one chain per source so the new source is ready when chosen
  wire irc_div      = fcs_tap(irc_lvl, irc_cnt_reg, reference_divider_reg);
  wire erc_div      = fcs_tap(erc_lvl, erc_cnt_reg, reference_divider_reg);
  wire irc_div_rise = irc_div & ~irc_div_prev_reg;
  wire erc_div_rise = erc_div & ~erc_div_prev_reg;
  wire new_ref_rise = reference_select_reg ? irc_div_rise : erc_div_rise;
  // fll reference follows the committed source only
  wire ref_div_lvl  = reference_status_reg ? irc_div : erc_div; // [R12]

  always @(posedge aclk) begin
    if (!aresetn) begin
      irc_cnt_reg          <= {CNT_W{1'b0}};
      erc_cnt_reg          <= {CNT_W{1'b0}};
      irc_div_prev_reg     <= 1'b0;
      erc_div_prev_reg     <= 1'b0;
      reference_status_reg <= `FCS_RST_REFSEL;
      ref_sw_cnt_reg       <= 2'd0;
      fll_relock_reg       <= 1'b0;
    end else begin
      irc_cnt_reg      <= irc_rise ? irc_cnt_reg + 1'b1 : irc_cnt_reg;
      erc_cnt_reg      <= erc_rise ? erc_cnt_reg + 1'b1 : erc_cnt_reg;
      irc_div_prev_reg <= irc_div;
      erc_div_prev_reg <= erc_div;
      fll_relock_reg   <= 1'b0;
      if (reference_select_reg == reference_status_reg) begin
        ref_sw_cnt_reg <= 2'd0;
      end else if (new_ref_rise) begin
        if (ref_sw_cnt_reg == `FCS_SWITCH_CYCLES - 1) begin
          reference_status_reg <= reference_select_reg; // [R02]
          fll_relock_reg       <= 1'b1; // [R02]
          ref_sw_cnt_reg       <= 2'd0;
        end else begin
          ref_sw_cnt_reg <= ref_sw_cnt_reg + 2'd1;
        end
      end
    end
  end

  // output mux: commit after full cycles of the new clock, only while both are low
  wire old_lvl  = fcs_pick(clock_status_reg, fll_lvl, irc_lvl, erc_lvl); // [R19]
  wire new_lvl  = fcs_pick(clock_select_reg, fll_lvl, irc_lvl, erc_lvl); // [R19]
  wire new_rise = fcs_pick(clock_select_reg, fll_rise, irc_rise, erc_rise);
  wire cs_legal = (clock_select_reg != `FCS_CS_RSVD);
  wire cs_ready = (clk_sw_cnt_reg == `FCS_SWITCH_CYCLES);

  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_status_reg <= `FCS_RST_CLKSEL;
      clk_sw_cnt_reg   <= 2'd0;
    end else if (!cs_legal || clock_select_reg == clock_status_reg ||
                 (wr_go && wr_idx == 3'd0)) begin
      // a fresh control write restarts the count so cycles of an older target never carry over
      clk_sw_cnt_reg <= 2'd0;
    end else if (cs_ready) begin
      if (!old_lvl && !new_lvl && !main_clock_reg) begin
        clock_status_reg <= clock_select_reg; // [R03] [R21]
        clk_sw_cnt_reg   <= 2'd0;
      end
    end else if (new_rise) begin
      // a silent new clock never reaches the count, so the old clock stays
      clk_sw_cnt_reg <= clk_sw_cnt_reg + 2'd1; // [R03]
    end
  end

  // generated clocks, all static in stop except enabled aux references
  wire bypass  = (clock_select_reg != `FCS_CS_FLL);
  wire bd_tap  = (bus_divider_reg == 2'd0) ? main_clock_reg : bus_cnt_reg[bus_divider_reg - 2'd1];
  wire ffe_ok  = ({1'b0, reference_divider_reg} >=
                  {2'b00, bus_divider_reg} + `FCS_BUS_DIVIDER_QUAL_BASE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      main_clock_reg <= 1'b0;
      main_prev_reg  <= 1'b0;
      bus_cnt_reg    <= 3'd0;
      bus_clock_reg  <= 1'b0;
      irc_out_reg    <= 1'b0;
      erc_out_reg    <= 1'b0;
      ffclk_reg      <= 1'b0;
      ffe_reg        <= 1'b1;
      fll_enable_reg <= 1'b1;
      irc_osc_en_reg <= 1'b1;
      erc_osc_en_reg <= 1'b0;
    end else begin
      main_clock_reg <= old_lvl & ~stop_mode; // [R21]
      main_prev_reg  <= main_clock_reg;
      if (main_clock_reg && !main_prev_reg) begin
        bus_cnt_reg <= bus_cnt_reg + 3'd1;
      end
      // tap read fresh every cycle so a new ratio applies at once
      bus_clock_reg  <= bd_tap; // [R04] [R17]
      irc_out_reg    <= irc_lvl & internal_ref_output_enable_reg &
                        (~stop_mode | internal_ref_stop_enable_reg); // [R06] [R09]
      erc_out_reg    <= erc_lvl & external_ref_output_enable_reg &
                        (~stop_mode | external_ref_stop_enable_reg); // [R11] [R13]
      ffclk_reg      <= ref_div_lvl & ~stop_mode; // [R14]
      ffe_reg        <= (clock_status_reg == `FCS_CS_FLL) ? 1'b1 : ffe_ok; // [R15] [R16]
      fll_enable_reg <= ~stop_mode &
                        ~(bypass & fll_power_down_reg & ~background_debug_mode); // [R05] [R20]
      irc_osc_en_reg <= ~stop_mode |
                        (internal_ref_output_enable_reg & internal_ref_stop_enable_reg); // [R09]
      erc_osc_en_reg <= stop_mode ?
                        (external_ref_output_enable_reg & external_ref_stop_enable_reg) :
                        (external_ref_output_enable_reg | ~reference_select_reg |
                         ~reference_status_reg | (clock_select_reg == `FCS_CS_ERC)); // [R13]
    end
  end

  // status back to the register side through two stages
  always @(posedge aclk) begin
    if (!aresetn) begin
      refst_s1_reg <= `FCS_RST_REFSEL;
      refst_s2_reg <= `FCS_RST_REFSEL;
      clkst_s1_reg <= `FCS_RST_CLKSEL;
      clkst_s2_reg <= `FCS_RST_CLKSEL;
    end else begin
      refst_s1_reg <= reference_status_reg; // [R22]
      refst_s2_reg <= refst_s1_reg;
      clkst_s1_reg <= clock_status_reg; // [R22]
      clkst_s2_reg <= clkst_s1_reg;
    end
  end

  // port drive
  assign s_axi_awready             = awready_reg;
  assign s_axi_wready              = wready_reg;
  assign s_axi_bresp               = bresp_reg;
  assign s_axi_bvalid              = bvalid_reg;
  assign s_axi_arready             = arready_reg;
  assign s_axi_rdata               = rdata_reg;
  assign s_axi_rresp               = rresp_reg;
  assign s_axi_rvalid              = rvalid_reg;
  assign main_clock_out            = main_clock_reg;
  assign bus_clock_out             = bus_clock_reg;
  assign internal_ref_clock_out    = irc_out_reg;
  assign external_ref_clock_out    = erc_out_reg;
  assign fixed_frequency_clock     = ffclk_reg;
  assign fixed_frequency_qualifier = ffe_reg;
  assign fll_enable                = fll_enable_reg;
  assign fll_reference_out         = ffclk_reg; // [R18]
  assign fll_relock                = fll_relock_reg;
  assign fll_multiplier            = `FCS_FLL_MULT; // [R18]
  assign internal_ref_osc_enable   = irc_osc_en_reg;
  assign external_ref_osc_enable   = erc_osc_en_reg;
  // larger trim slows the oscillator; it also moves main clock in internal modes
  assign trim_out                  = trim_register_reg; // [R07]
  assign fine_adjust_out           = fine_adjust_bit_reg; // [R07]

endmodule // fcs_clock_source

`default_nettype wire

// >>> dv/fcs_clock_source_props.sv
// port assertions for the clock source control
`default_nettype none
module fcs_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channel
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // clocks and state
  input wire logic        stop_mode,
  input wire logic        background_debug_mode,
  input wire logic        main_clock_out,
  input wire logic        fixed_frequency_clock,
  input wire logic        fll_reference_out,
  input wire logic        fll_enable,
  input wire logic        fll_relock,
  input wire logic [10:0] fll_multiplier
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_mult; fll_multiplier == 11'h400; endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong");
  property p_ffref; fll_reference_out == fixed_frequency_clock; endproperty
  a_ffref: assert property (p_ffref) else $error("reference differs");
  property p_stmain; stop_mode && $past(stop_mode) |-> !main_clock_out; endproperty
  a_stmain: assert property (p_stmain) else $error("main runs in stop");
  property p_stff; stop_mode && $past(stop_mode) |-> !fixed_frequency_clock; endproperty
  a_stff: assert property (p_stff) else $error("fixed clock runs in stop");
  property p_dbg; (background_debug_mode && !stop_mode) [*2] |-> fll_enable; endproperty
  a_dbg: assert property (p_dbg) else $error("fll off in debug");
  property p_relock; fll_relock |=> !fll_relock; endproperty
  a_relock: assert property (p_relock) else $error("relock too long");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("response dropped");
  property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken early");
endmodule // fcs_props
bind fcs_clock_source fcs_props u_props (.*);
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the clock source control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, stop_mode = 0, background_debug_mode = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, trim_out;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf, pc = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic main_clock_out, bus_clock_out, internal_ref_clock_out, external_ref_clock_out;
  logic fixed_frequency_clock, fixed_frequency_qualifier, fll_enable, fll_reference_out;
  logic fll_relock, internal_ref_osc_enable, external_ref_osc_enable, fine_adjust_out;
  logic [10:0] fll_multiplier;
  logic [33:0] q[$];
  int failures = 0, compares = 0, cyc = 0, n, m, i;
  // source pins at periods of 4, 8 and 16 cycles
  wire fll_clk_in = pc[1];
  wire internal_ref_clk_in = pc[2];
  wire external_ref_clk_in = pc[3];
  fcs_clock_source DUT (.*);
  always #50 aclk = ~aclk;
  task chk(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // result monitor and timeout
  always @(posedge aclk) begin
    pc <= pc + 4'h1;
    cyc++;
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (cyc > 20000) begin
      failures++;
      final_report;
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (!s_axi_bready) s_axi_bready <= $urandom % 2;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (!s_axi_rready) s_axi_rready <= $urandom % 2;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 0;
  endtask
  // bus clock period in system cycles
  task per(output int p);
    repeat (2) @(posedge bus_clock_out);
    p = cyc;
    @(posedge bus_clock_out);
    p = cyc - p;
  endtask
  // rising edges of both aux clocks over 64 cycles
  task rises(output int a, output int b);
    logic pi, pe;
    a = 0;
    b = 0;
    pi = 1;
    pe = 1;
    repeat (64) begin
      @(posedge aclk);
      a += int'(internal_ref_clock_out && !pi);
      b += int'(external_ref_clock_out && !pe);
      pi = internal_ref_clock_out;
      pe = external_ref_clock_out;
    end
  endtask
  initial begin
    void'($urandom(56));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 32'h20);
    rd(8'h04, 32'h01);
    rd(8'h0c, 32'h19);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'hff, 2'h2);
    wr(8'h0c, 32'h0);
    $display("end registers");
    for (i = 0; i < 4; i++) begin
      wr(8'h04, i);
      per(n);
      chk(n, 32'h4 << i);
    end
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    repeat (100) @(posedge aclk);
    rd(8'h0c, 32'h18);
    @(posedge fixed_frequency_clock) n = cyc;
    @(posedge fixed_frequency_clock) chk(cyc - n, 32'h10);
    wr(8'h00, 32'h21);
    repeat (100) @(posedge aclk);
    rd(8'h0c, 32'h0b);
    per(n);
    chk(n, 32'h10);
    @(posedge fixed_frequency_clock) n = cyc;
    @(posedge fixed_frequency_clock) chk(cyc - n, 32'h8);
    $display("end mode switch");
    wr(8'h04, 32'h5);
    repeat (3) @(posedge aclk);
    chk(fll_enable, 0);
    background_debug_mode <= 1;
    repeat (3) @(posedge aclk);
    chk(fll_enable, 1);
    background_debug_mode <= 0;
    for (i = 0; i < 8; i++) begin
      wr(8'h04, i / 2);
      wr(8'h00, 32'h21 | ((i / 2 + 1 + i % 2) << 2));
      repeat (3) @(posedge aclk);
      chk(fixed_frequency_qualifier, i % 2);
    end
    wr(8'h00, 32'h23);
    repeat (100) @(posedge aclk);
    rd(8'h0c, 32'h0b);
    wr(8'h00, 32'h02);
    repeat (100) @(posedge aclk);
    rd(8'h0c, 32'h0c);
    per(n);
    chk(n, 32'h80);
    $display("end qualifier");
    wr(8'h00, 32'h61);
    wr(8'h04, 32'h09);
    rises(n, m);
    chk(n != 0, 1);
    chk(m != 0, 1);
    stop_mode <= 1;
    rises(n, m);
    chk(n + m, 0);
    chk({internal_ref_osc_enable, external_ref_osc_enable}, 0);
    wr(8'h00, 32'he1);
    wr(8'h04, 32'h19);
    rises(n, m);
    chk(n != 0, 1);
    chk(m != 0, 1);
    chk({internal_ref_osc_enable, external_ref_osc_enable}, 2'h3);
    stop_mode <= 0;
    $display("end aux clocks");
    n = $urandom % 512;
    wr(8'h08, n);
    repeat (2) @(posedge aclk);
    chk({fine_adjust_out, trim_out}, n);
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(8'h08, n);
    $display("end trim");
    final_report;
  end
endmodule // tb_top
`default_nettype wire
